/* src/dim_pkg.sv */
// Constants and types of the digital input function mapper.
// Behaviour
// - Selectors take 0..16 but not 13, reset 0, change when stopped.
// - Code 0 drives nothing, status only.
// - Code 1 closed starts, open stops, by level.
// - Codes 2/3 edge start/stop, need pairing.
// - Code 4 closed enables, open disables, no ramp.
// - Code 5 open local, closed remote.
// - Code 6 jog while any closed.
// - Code 7 selects forward or reverse contactor.
// - Code 8 open raises external fault.
// - Code 9 open raises external alarm only.
// - Code 10 open disables braking at once.
// - Code 11 closing edge resets fault once.
// - Code 12 edges load user sets, not enabled.
// - Code 14 emergency start, third input only.
// - Emergency start ignores protections and source.
// - Code 15 thermistor alarm, sixth input only.
// - Code 16 thermistor fault, sixth input only.
package dim_pkg;

	// Input count and selector width.
	localparam int NUM_IN = 4;
	localparam int CODE_W = 5;
	localparam logic [CODE_W-1:0] CODE_RST = 5'h00;

	// Function codes.
	localparam logic [CODE_W-1:0] FN_UNUSED = 5'h00;
	localparam logic [CODE_W-1:0] FN_RUN = 5'h01;
	localparam logic [CODE_W-1:0] FN_START3 = 5'h02;
	localparam logic [CODE_W-1:0] FN_STOP3 = 5'h03;
	localparam logic [CODE_W-1:0] FN_GEN_EN = 5'h04;
	localparam logic [CODE_W-1:0] FN_COMMAND_SOURCE_SELECT = 5'h05;
	localparam logic [CODE_W-1:0] FN_JOG = 5'h06;
	localparam logic [CODE_W-1:0] FN_DIR = 5'h07;
	localparam logic [CODE_W-1:0] FN_EXT_FLT = 5'h08;
	localparam logic [CODE_W-1:0] FN_EXT_ALM = 5'h09;
	localparam logic [CODE_W-1:0] FN_BRAKE = 5'h0A;
	localparam logic [CODE_W-1:0] FN_RESET = 5'h0B;
	localparam logic [CODE_W-1:0] FN_LOAD = 5'h0C;
	localparam logic [CODE_W-1:0] FN_RSVD = 5'h0D;
	localparam logic [CODE_W-1:0] FN_EMERG = 5'h0E;
	localparam logic [CODE_W-1:0] FN_TH_ALM = 5'h0F;
	localparam logic [CODE_W-1:0] FN_TH_FLT = 5'h10;

	// Inputs that own the special codes (index 0 is the third input).
	localparam int EMERG_IN = 0;
	localparam int THERM_IN = 3;

	// Register byte offsets.
	localparam logic [7:0] OFS_SEL0 = 8'h00;
	localparam logic [7:0] OFS_LEVEL = 8'h10;
	localparam logic [7:0] OFS_IRQ_ST = 8'h14;
	localparam logic [7:0] OFS_IRQ_MSK = 8'h18;
	localparam logic [7:0] OFS_CMD = 8'h1C;
	localparam logic [7:0] SEL_STEP = 8'h04;

	// Interrupt status bit positions.
	localparam int IRQ_W = 8;
	localparam int IB_START = 0;
	localparam int IB_STOP = 1;
	localparam int IB_RESET = 2;
	localparam int IB_LOAD1 = 3;
	localparam int IB_LOAD2 = 4;
	localparam int IB_LOAD_REF = 5;
	localparam int IB_THERM = 6;
	localparam int IB_EXT_FLT = 7;

	// Debounce time and its cycle count at the bus clock.
	localparam int CLK_MHZ = 125;
	localparam int DEB_TIME_US = 1000;
	localparam int DEB_DEF_CYC = DEB_TIME_US * CLK_MHZ;
	localparam int CNT_W = 17;

	// Decoded commands handed to the motor control core.
	typedef struct packed {
		logic run_used;
		logic run_req;
		logic start_pulse;
		logic stop_pulse;
		logic en_used;
		logic gen_enable;
		logic remote;
		logic jog;
		logic forward_contactor;
		logic reverse_contactor;
		logic ext_fault;
		logic ext_alarm;
		logic brake_permit;
		logic fault_reset;
		logic load_user1;
		logic load_user2;
		logic emerg_used;
		logic emerg_run;
		logic therm_alarm;
		logic therm_fault;
	} dim_cmd_type;

endpackage

/* src/dim_mapper.sv */
// Digital input function mapper with its AHB-Lite register slave.
//
// The implementer's own choices: the AHB-Lite interface to the registers and the register addresses.
`timescale 1ns/1ns
module dim_mapper
	import dim_pkg::*;
#(
	parameter int unsigned DEB_CYCLES = DEB_DEF_CYC
) (
	// Clock and reset.
	input wire logic hclk,
	input wire logic hresetn,
	// AHB-Lite slave port.
	input wire logic hsel,
	input wire logic [31:0] haddr,
	input wire logic [1:0] htrans,
	input wire logic hwrite,
	input wire logic [2:0] hsize,
	input wire logic [31:0] hwdata,
	input wire logic hready,
	output logic hreadyout,
	output logic hresp,
	output logic [31:0] hrdata,
	// Field contacts, asynchronous to hclk.
	input wire logic control_input_three,
	input wire logic control_input_four,
	input wire logic control_input_five,
	input wire logic control_input_six,
	// Motor state from the control core.
	input wire logic motor_stopped,
	input wire logic motor_enabled,
	// Decoded commands and interrupt.
	output dim_cmd_type cmd,
	output logic irq
);

	// Debounce end count, at least one cycle.
	localparam logic [CNT_W-1:0] DEB_LAST =
		CNT_W'((DEB_CYCLES > 1) ? DEB_CYCLES - 1 : 1);

	// Raw pins gathered, index 0 is the third input.
	wire [NUM_IN-1:0] pin_raw = {control_input_six,
		control_input_five, control_input_four,
		control_input_three};

	logic [CODE_W-1:0] sel_r [NUM_IN]; // Function selectors.
	// Selectors packed side by side, so decode sees every change.
	wire [NUM_IN*CODE_W-1:0] sel_flat;
	logic [NUM_IN-1:0] sync1_r; // First synchroniser stage.
	logic [NUM_IN-1:0] sync2_r; // Second synchroniser stage.
	logic [NUM_IN-1:0] lvl_r; // Debounced levels.
	logic [NUM_IN-1:0] lvl_q_r; // Levels one cycle ago.
	logic [CNT_W-1:0] cnt_r [NUM_IN]; // Debounce counters.
	logic [IRQ_W-1:0] irq_st_r; // Sticky event bits.
	logic [IRQ_W-1:0] irq_msk_r; // Interrupt mask.
	logic wr_pend_r; // Write data phase pending.
	logic [7:0] wr_addr_r; // Address of that write.
	logic [31:0] hrdata_r; // Read data register.
	dim_cmd_type cmd_r; // Registered commands.
	dim_cmd_type cmd_nxt; // Next commands.

	// Mask of inputs whose selector holds a code. The selectors come
	// in as an argument: a continuous assignment only wakes up on its
	// operands, so a function reading module state would go stale.
	function automatic logic [NUM_IN-1:0] sel_is(
		input logic [NUM_IN*CODE_W-1:0] s,
		input logic [CODE_W-1:0] code);
		logic [NUM_IN-1:0] m;
		m = '0;
		for (int i = 0; i < NUM_IN; i++) begin
			m[i] = (s[i*CODE_W +: CODE_W] == code);
		end
		return m;
	endfunction

	// Whether an input may hold a code; reserved and foreign
	// special codes are refused so no input can misbehave.
	function automatic logic code_ok(input int idx,
		input logic [CODE_W-1:0] code);
		logic ok;
		ok = (code <= FN_TH_FLT) && (code != FN_RSVD);
		if (code == FN_EMERG) begin
			ok = (idx == EMERG_IN);
		end
		if (code == FN_TH_ALM || code == FN_TH_FLT) begin
			ok = (idx == THERM_IN);
		end
		return ok;
	endfunction

	// Bus decode: zero wait states, always OKAY.
	wire addr_ok = hsel & htrans[1] & hready;
	wire rd_acc = addr_ok & ~hwrite;
	wire wr_acc = addr_ok & hwrite;
	wire [7:0] a_lo = haddr[7:0];
	wire rd_irq = rd_acc & (a_lo == OFS_IRQ_ST);
	assign hreadyout = 1'b1;
	assign hresp = 1'b0;
	assign hrdata = hrdata_r;

	// Synchroniser, debounce and selector storage per input.
	genvar g;
	generate
		for (g = 0; g < NUM_IN; g++) begin : g_in
			wire sel_hit = wr_pend_r &&
				(wr_addr_r == OFS_SEL0 + SEL_STEP * 8'(g));
			wire [CODE_W-1:0] wcode = hwdata[CODE_W-1:0];
			wire take = sel_hit && motor_stopped &&
				(hwdata[31:CODE_W] == '0) && code_ok(g, wcode);

			// Pack this selector into the shared decode word.
			assign sel_flat[g*CODE_W +: CODE_W] = sel_r[g];

			// Selector changes only with the motor stopped.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sel_r[g] <= CODE_RST;
				end else if (take) begin
					sel_r[g] <= wcode;
				end
			end

			// Two flops, then a level must hold DEB_CYCLES.
			always_ff @(posedge hclk or negedge hresetn) begin
				if (!hresetn) begin
					sync1_r[g] <= 1'b0;
					sync2_r[g] <= 1'b0;
					lvl_r[g] <= 1'b0;
					cnt_r[g] <= '0;
				end else begin
					sync1_r[g] <= pin_raw[g];
					sync2_r[g] <= sync1_r[g];
					if (sync2_r[g] == lvl_r[g]) begin
						cnt_r[g] <= '0;
					end else if (cnt_r[g] == DEB_LAST) begin
						lvl_r[g] <= sync2_r[g];
						cnt_r[g] <= '0;
					end else begin
						cnt_r[g] <= cnt_r[g] + 1'b1;
					end
				end
			end
		end
	endgenerate

	// Edge detection on the debounced levels only.
	wire [NUM_IN-1:0] rise = lvl_r & ~lvl_q_r;
	wire [NUM_IN-1:0] fall = ~lvl_r & lvl_q_r;

	// Per-function input masks; code 0 appears in none.
	wire [NUM_IN-1:0] m_run = sel_is(sel_flat, FN_RUN);
	wire [NUM_IN-1:0] m_st3 = sel_is(sel_flat, FN_START3);
	wire [NUM_IN-1:0] m_sp3 = sel_is(sel_flat, FN_STOP3);
	wire [NUM_IN-1:0] m_en = sel_is(sel_flat, FN_GEN_EN);
	wire [NUM_IN-1:0] m_lr = sel_is(sel_flat, FN_COMMAND_SOURCE_SELECT);
	wire [NUM_IN-1:0] m_jog = sel_is(sel_flat, FN_JOG);
	wire [NUM_IN-1:0] m_dir = sel_is(sel_flat, FN_DIR);
	wire [NUM_IN-1:0] m_ef = sel_is(sel_flat, FN_EXT_FLT);
	wire [NUM_IN-1:0] m_ea = sel_is(sel_flat, FN_EXT_ALM);
	wire [NUM_IN-1:0] m_br = sel_is(sel_flat, FN_BRAKE);
	wire [NUM_IN-1:0] m_rst = sel_is(sel_flat, FN_RESET);
	wire [NUM_IN-1:0] m_ld = sel_is(sel_flat, FN_LOAD);
	wire [NUM_IN-1:0] m_em = sel_is(sel_flat, FN_EMERG);
	wire [NUM_IN-1:0] m_ta = sel_is(sel_flat, FN_TH_ALM);
	wire [NUM_IN-1:0] m_tf = sel_is(sel_flat, FN_TH_FLT);

	// Three-wire edges count only while both halves exist.
	wire pair3 = (|m_st3) & (|m_sp3);
	wire ld1_req = |(m_ld & rise);
	wire ld2_req = |(m_ld & fall);

	// Command decode from levels and edges.
	always_comb begin
		cmd_nxt = '0;
		cmd_nxt.run_used = |m_run;
		cmd_nxt.run_req = |(m_run & lvl_r);
		cmd_nxt.start_pulse = pair3 & |(m_st3 & rise);
		cmd_nxt.stop_pulse = pair3 & |(m_sp3 & fall);
		cmd_nxt.en_used = |m_en;
		// Any open enable input disables; the core stops hard.
		cmd_nxt.gen_enable = &(~m_en | lvl_r);
		cmd_nxt.remote = |(m_lr & lvl_r);
		cmd_nxt.jog = |(m_jog & lvl_r);
		// Forward is the rest state when no input is assigned.
		cmd_nxt.forward_contactor = ~|(m_dir & lvl_r);
		cmd_nxt.reverse_contactor = |(m_dir & lvl_r);
		cmd_nxt.ext_fault = |(m_ef & ~lvl_r);
		cmd_nxt.ext_alarm = |(m_ea & ~lvl_r);
		cmd_nxt.brake_permit = &(~m_br | lvl_r);
		cmd_nxt.fault_reset = |(m_rst & rise);
		cmd_nxt.load_user1 = ld1_req & ~motor_enabled;
		cmd_nxt.load_user2 = ld2_req & ~motor_enabled;
		// Not gated by source or protection state on purpose.
		cmd_nxt.emerg_used = m_em[EMERG_IN];
		cmd_nxt.emerg_run = m_em[EMERG_IN] & lvl_r[EMERG_IN];
		// An open thermistor loop is the tripped state.
		cmd_nxt.therm_alarm =
			m_ta[THERM_IN] & ~lvl_r[THERM_IN];
		cmd_nxt.therm_fault =
			m_tf[THERM_IN] & ~lvl_r[THERM_IN];
	end

	// Events that set sticky interrupt bits.
	wire th_now = cmd_nxt.therm_alarm | cmd_nxt.therm_fault;
	wire th_was = cmd_r.therm_alarm | cmd_r.therm_fault;
	wire [IRQ_W-1:0] ev;
	assign ev[IB_START] = cmd_nxt.start_pulse;
	assign ev[IB_STOP] = cmd_nxt.stop_pulse;
	assign ev[IB_RESET] = cmd_nxt.fault_reset;
	assign ev[IB_LOAD1] = cmd_nxt.load_user1;
	assign ev[IB_LOAD2] = cmd_nxt.load_user2;
	assign ev[IB_LOAD_REF] = (ld1_req | ld2_req) & motor_enabled;
	assign ev[IB_THERM] = th_now & ~th_was;
	assign ev[IB_EXT_FLT] = cmd_nxt.ext_fault & ~cmd_r.ext_fault;

	// A read clears the status, but an event in that cycle wins.
	wire [IRQ_W-1:0] irq_nxt =
		(irq_st_r & ~{IRQ_W{rd_irq}}) | ev;

	// Read mux sampled in the address phase.
	wire [31:0] rd_mux =
		(a_lo == OFS_SEL0) ? 32'(sel_r[0]) :
		(a_lo == OFS_SEL0 + SEL_STEP) ? 32'(sel_r[1]) :
		(a_lo == OFS_SEL0 + 2 * SEL_STEP) ? 32'(sel_r[2]) :
		(a_lo == OFS_SEL0 + 3 * SEL_STEP) ? 32'(sel_r[3]) :
		(a_lo == OFS_LEVEL) ? 32'(lvl_r) :
		(a_lo == OFS_IRQ_ST) ? 32'(irq_st_r) :
		(a_lo == OFS_IRQ_MSK) ? 32'(irq_msk_r) :
		(a_lo == OFS_CMD) ? 32'(cmd_r) : 32'h00000000;

	// Bus phase tracking and read data capture.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			wr_pend_r <= 1'b0;
			wr_addr_r <= 8'h00;
			hrdata_r <= 32'h00000000;
		end else begin
			wr_pend_r <= wr_acc;
			if (wr_acc) begin
				wr_addr_r <= a_lo;
			end
			if (rd_acc) begin
				hrdata_r <= rd_mux;
			end
		end
	end

	// Command, edge history, interrupt state.
	always_ff @(posedge hclk or negedge hresetn) begin
		if (!hresetn) begin
			cmd_r <= '0;
			lvl_q_r <= '0;
			irq_st_r <= '0;
			irq_msk_r <= '0;
		end else begin
			cmd_r <= cmd_nxt;
			lvl_q_r <= lvl_r;
			irq_st_r <= irq_nxt;
			if (wr_pend_r && wr_addr_r == OFS_IRQ_MSK) begin
				irq_msk_r <= hwdata[IRQ_W-1:0];
			end
		end
	end

	assign cmd = cmd_r;
	assign irq = |(irq_st_r & irq_msk_r);

	// Selector write refused while the motor runs.
	a_sel_frozen: assert property (@(posedge hclk)
		disable iff (!hresetn)
		!motor_stopped |=> $stable(sel_r[0]) && $stable(sel_r[3]))
		else $error("selector changed with motor running");

	// Code 0 on every input leaves all commands idle.
	a_unused_idle: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(sel_is(sel_flat, FN_UNUSED) == '1) |=> !cmd.run_req && !cmd.jog
		&& !cmd.remote && !cmd.ext_fault && cmd.gen_enable)
		else $error("unused input drove a command");

	// Start follows a closed start/stop input by one cycle.
	a_run_level: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_run & lvl_r) |=> cmd.run_req)
		else $error("start/stop level not followed");

	// Three-wire pulses need both halves and last one cycle.
	a_three_wire: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(cmd.start_pulse || cmd.stop_pulse) |->
		$past(pair3) ##1 !cmd.start_pulse && !cmd.stop_pulse)
		else $error("unpaired or long three-wire pulse");

	// An open enable input disables on the next cycle.
	a_gen_disable: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_en & ~lvl_r) |=> !cmd.gen_enable)
		else $error("general disable missed");

	// Jog follows any closed jog input.
	a_jog_any: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_jog & lvl_r) |=> cmd.jog)
		else $error("jog not enabled");

	// Exactly one contactor is closed once the first decode has landed;
	// in the edge right after release both still show their reset zero.
	a_dir_excl: assert property (@(posedge hclk)
		disable iff (!hresetn)
		$past(hresetn) |->
		cmd.forward_contactor != cmd.reverse_contactor)
		else $error("contactors not exclusive");

	// Fault reset never repeats for a held contact.
	a_reset_once: assert property (@(posedge hclk)
		disable iff (!hresetn)
		cmd.fault_reset |=> !cmd.fault_reset)
		else $error("fault reset repeated");

	// No user load while the motor is enabled.
	a_load_block: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(cmd.load_user1 || cmd.load_user2) |->
		!$past(motor_enabled))
		else $error("user set loaded with motor enabled");

	// Special codes stay on their own inputs.
	a_code_home: assert property (@(posedge hclk)
		disable iff (!hresetn)
		sel_r[1] < FN_RSVD && sel_r[2] < FN_RSVD
		&& sel_r[0] <= FN_EMERG && sel_r[3] != FN_EMERG)
		else $error("special code on wrong input");

	// Debounced level moves only after a full count.
	a_deb_hold: assert property (@(posedge hclk)
		disable iff (!hresetn)
		$changed(lvl_r[0]) |-> $past(cnt_r[0]) == DEB_LAST)
		else $error("level changed before debounce");

	// A closed local/remote input selects the remote source.
	a_remote_sel: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_lr & lvl_r) |=> cmd.remote)
		else $error("remote source not selected");

	// An open external fault input raises the fault next cycle.
	a_ext_fault: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_ef & ~lvl_r) |=> cmd.ext_fault)
		else $error("external fault missed");

	// An open external alarm input raises the alarm next cycle.
	a_ext_alarm: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_ea & ~lvl_r) |=> cmd.ext_alarm)
		else $error("external alarm missed");

	// Any open brake input withdraws the braking permit.
	a_brake_off: assert property (@(posedge hclk)
		disable iff (!hresetn)
		|(m_br & ~lvl_r) |=> !cmd.brake_permit)
		else $error("braking not disabled");

	// A closed emergency input always runs, whatever else is active.
	a_emerg_run: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(sel_r[EMERG_IN] == FN_EMERG) && lvl_r[EMERG_IN]
		|=> cmd.emerg_run)
		else $error("emergency start ignored");

	// An open thermistor loop in alarm mode warns without a fault.
	a_therm_alarm: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(sel_r[THERM_IN] == FN_TH_ALM) && !lvl_r[THERM_IN]
		|=> cmd.therm_alarm && !cmd.therm_fault)
		else $error("thermistor alarm wrong");

	// An open thermistor loop in fault mode raises the fault only.
	a_therm_fault: assert property (@(posedge hclk)
		disable iff (!hresetn)
		(sel_r[THERM_IN] == FN_TH_FLT) && !lvl_r[THERM_IN]
		|=> cmd.therm_fault && !cmd.therm_alarm)
		else $error("thermistor fault wrong");

	// A start event is kept even when a status read clears alongside.
	a_irq_set_wins: assert property (@(posedge hclk)
		disable iff (!hresetn)
		ev[IB_START] |=> irq_st_r[IB_START])
		else $error("start event lost from status");

endmodule // dim_mapper

/* tb/dim_contacts.sv */
// Field contact model that drives the four control inputs.
`timescale 1ns/1ns
module dim_contacts (
	// Wanted contact states, bit 0 is the third input.
	input wire logic [3:0] closed_in,
	// Contact lines towards the mapper.
	output wire logic control_input_three,
	output wire logic control_input_four,
	output wire logic control_input_five,
	output wire logic control_input_six
);
	// Contacts settle a few ns off the clock, so the sync stages see them
	// as truly asynchronous inputs.
	assign #3 control_input_three = closed_in[0];
	assign #3 control_input_four = closed_in[1];
	assign #3 control_input_five = closed_in[2];
	assign #3 control_input_six = closed_in[3];
endmodule // dim_contacts

/* tb/testbench.sv */
// Self-checking testbench of the digital input function mapper.
`timescale 1ns/1ns
module testbench
	import dim_pkg::*;
;
	// Bus, motor state and contact commands driven by the bench.
	logic hclk = 1'b0;
	logic hresetn = 1'b0;
	logic hsel = 1'b0;
	logic hwrite = 1'b0;
	logic [1:0] htrans = 2'h0;
	logic [31:0] haddr = 32'h0;
	logic [31:0] hwdata = 32'h0;
	logic motor_stopped = 1'b1;
	logic motor_enabled = 1'b0;
	logic [3:0] want = 4'h0;
	// Design outputs and contact lines.
	wire logic hreadyout, hresp, irq, c3, c4, c5, c6;
	wire logic [31:0] hrdata;
	wire dim_cmd_type cmd;
	// Counters, pulse tallies and scratch data.
	int fail_count = 0;
	int tests_run = 0;
	int pc[5] = '{0, 0, 0, 0, 0};
	int p;
	logic [31:0] d;
	logic [4:0] lv[8] = '{FN_RUN, FN_GEN_EN, FN_COMMAND_SOURCE_SELECT, FN_JOG, FN_DIR,
		FN_EXT_FLT, FN_EXT_ALM, FN_BRAKE};

	// A short debounce keeps each contact change near a dozen cycles.
	dim_mapper #(.DEB_CYCLES(4)) uut (.hclk(hclk), .hresetn(hresetn),
		.hsel(hsel), .haddr(haddr), .htrans(htrans), .hwrite(hwrite),
		.hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
		.hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
		.control_input_three(c3), .control_input_four(c4),
		.control_input_five(c5), .control_input_six(c6),
		.motor_stopped(motor_stopped), .motor_enabled(motor_enabled),
		.cmd(cmd), .irq(irq));
	dim_contacts field (.closed_in(want), .control_input_three(c3),
		.control_input_four(c4), .control_input_five(c5),
		.control_input_six(c6));

	// The 125 MHz bus clock.
	always #4 hclk = ~hclk;

	// Tally every cycle of each pulse, so a stretched pulse counts twice.
	always @(posedge hclk) begin
		if (cmd.start_pulse === 1'b1) pc[0] <= pc[0] + 1;
		if (cmd.stop_pulse === 1'b1) pc[1] <= pc[1] + 1;
		if (cmd.fault_reset === 1'b1) pc[2] <= pc[2] + 1;
		if (cmd.load_user1 === 1'b1) pc[3] <= pc[3] + 1;
		if (cmd.load_user2 === 1'b1) pc[4] <= pc[4] + 1;
	end

	// Prints the verdict and ends the run.
	task close_out();
		if (fail_count == 0 && tests_run > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	// Compares one value and reports a mismatch at once.
	task chk(input string nm, input logic [31:0] ex,
		input logic [31:0] got);
		tests_run++;
		if (got !== ex) begin
			fail_count++;
			$display("[FAIL] %s expected %h seen %h", nm, ex, got);
		end
	endtask

	// Waits for an edge with hready high, giving up after 20 cycles.
	task rdy();
		int n;
		n = 0;
		@(posedge hclk);
		while (hreadyout !== 1'b1) begin
			n++;
			if (n > 20) begin
				fail_count++;
				$display("[FAIL] hready expected 1 seen %b", hreadyout);
				close_out();
			end
			@(posedge hclk);
		end
	endtask

	// One single word transfer; read data is taken at the data-phase edge.
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		@(posedge hclk);
		hsel <= 1'b1;
		htrans <= 2'h2;
		hwrite <= w;
		haddr <= {24'h0, a};
		rdy();
		htrans <= 2'h0;
		hwdata <= wd;
		rdy();
		d = hrdata;
	endtask

	// Byte address of a selector, index 0 being the third input.
	function automatic logic [7:0] sa(input int i);
		sa = OFS_SEL0 + SEL_STEP * 8'(i);
	endfunction

	// Moves one contact and waits out sync, debounce and decode.
	task pin(input int i, input logic v);
		@(posedge hclk);
		want[i] <= v;
		repeat (12) @(posedge hclk);
	endtask

	// Picks the command field that a level code drives.
	function automatic logic fld(input logic [4:0] c,
		input dim_cmd_type m);
		case (c)
			FN_RUN: fld = m.run_req;
			FN_GEN_EN: fld = m.gen_enable;
			FN_COMMAND_SOURCE_SELECT: fld = m.remote;
			FN_JOG: fld = m.jog;
			FN_DIR: fld = m.reverse_contactor;
			FN_EXT_FLT: fld = m.ext_fault;
			FN_EXT_ALM: fld = m.ext_alarm;
			default: fld = m.brake_permit;
		endcase
	endfunction

	// Reset values, an unmapped read and the default command word.
	task t_reset();
		for (int i = 0; i < 4; i++) begin
			bus(1'b0, sa(i), 32'h0);
			chk("selector", 32'h0, d);
		end
		bus(1'b0, OFS_IRQ_MSK, 32'h0);
		chk("mask", 32'h0, d);
		bus(1'b0, 8'h20, 32'h0);
		chk("unmapped", 32'h0, d);
		bus(1'b0, OFS_CMD, 32'h0);
		chk("cmd word", 32'h4880, d);
		chk("hresp", 32'h0, hresp);
	endtask

	// A two-cycle glitch is ignored; a code 0 input only shows as a level.
	task t_glitch();
		@(posedge hclk);
		want[0] <= 1'b1;
		repeat (2) @(posedge hclk);
		want[0] <= 1'b0;
		repeat (12) @(posedge hclk);
		bus(1'b0, OFS_LEVEL, 32'h0);
		chk("glitch level", 32'h0, d);
		pin(0, 1'b1);
		bus(1'b0, OFS_LEVEL, 32'h0);
		chk("level", 32'h1, d);
		chk("cmd", 32'h4880, 32'(cmd));
		pin(0, 1'b0);
	endtask

	// Writes refused while running and for codes outside each input's set.
	task t_sel();
		int si[7] = '{0, 1, 0, 0, 3, 2, 2};
		logic [31:0] sv[7] = '{32'h11, 32'h0E, 32'h0F, 32'h10, 32'h10,
			32'h0D, 32'h21};
		logic [31:0] se[7] = '{32'h0, 32'h0, 32'h0, 32'h0, 32'h10, 32'h0,
			32'h0};
		@(posedge hclk);
		motor_stopped <= 1'b0;
		bus(1'b1, sa(2), 32'h1);
		bus(1'b0, sa(2), 32'h0);
		chk("running write", 32'h0, d);
		motor_stopped <= 1'b1;
		for (int k = 0; k < 7; k++) begin
			bus(1'b1, sa(si[k]), sv[k]);
			bus(1'b0, sa(si[k]), 32'h0);
			chk("selector", se[k], d);
		end
		bus(1'b1, sa(3), 32'h0);
	endtask

	// Every level code on the fourth input, closed and then open.
	task t_level();
		logic ec;
		logic f;
		for (int k = 0; k < 8; k++) begin
			ec = !(lv[k] == FN_EXT_FLT || lv[k] == FN_EXT_ALM);
			bus(1'b1, sa(1), 32'(lv[k]));
			pin(1, 1'b1);
			f = fld(lv[k], cmd);
			chk("closed", 32'(ec), 32'(f));
			if (lv[k] == FN_DIR) begin
				chk("forward", 32'h0, cmd.forward_contactor);
			end
			pin(1, 1'b0);
			f = fld(lv[k], cmd);
			chk("opened", 32'(!ec), 32'(f));
		end
		bus(1'b1, sa(1), 32'h0);
	endtask

	// Three-wire start and stop, unpaired first, then the interrupt path.
	task t_edge();
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		bus(1'b1, sa(0), 32'(FN_START3));
		p = pc[0];
		pin(0, 1'b1);
		chk("unpaired start", 32'h0, pc[0] - p);
		pin(0, 1'b0);
		pin(1, 1'b1);
		bus(1'b1, sa(1), 32'(FN_STOP3));
		pin(0, 1'b1);
		chk("start pulses", 32'h1, pc[0] - p);
		p = pc[1];
		pin(1, 1'b0);
		chk("stop pulses", 32'h1, pc[1] - p);
		bus(1'b1, OFS_IRQ_MSK, 32'h1);
		bus(1'b0, OFS_IRQ_MSK, 32'h0);
		chk("mask", 32'h1, d);
		chk("irq raised", 32'h1, irq);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		chk("status", 32'h3, d);
		@(posedge hclk);
		chk("irq cleared", 32'h0, irq);
		bus(1'b1, OFS_IRQ_MSK, 32'h0);
		pin(0, 1'b0);
		bus(1'b1, sa(0), 32'h0);
		bus(1'b1, sa(1), 32'h0);
	endtask

	// Fault reset once per closing, and user loads refused while enabled.
	task t_pulse();
		int q;
		bus(1'b1, sa(2), 32'(FN_RESET));
		p = pc[2];
		pin(2, 1'b1);
		chk("held reset", 32'h1, pc[2] - p);
		pin(2, 1'b0);
		pin(2, 1'b1);
		chk("second reset", 32'h2, pc[2] - p);
		pin(2, 1'b0);
		bus(1'b1, sa(2), 32'(FN_LOAD));
		p = pc[3];
		q = pc[4];
		pin(2, 1'b1);
		pin(2, 1'b0);
		chk("load one", 32'h1, pc[3] - p);
		chk("load two", 32'h1, pc[4] - q);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		chk("load status", 32'h18, d & 32'h18);
		motor_enabled <= 1'b1;
		pin(2, 1'b1);
		chk("load refused", 32'h1, pc[3] - p);
		bus(1'b0, OFS_IRQ_ST, 32'h0);
		chk("refuse status", 32'h20, d);
		motor_enabled <= 1'b0;
		pin(2, 1'b0);
		bus(1'b1, sa(2), 32'h0);
	endtask

	// Emergency start follows the third input despite an external fault.
	task t_emerg();
		bus(1'b1, sa(1), 32'(FN_EXT_FLT));
		bus(1'b1, sa(0), 32'(FN_EMERG));
		pin(0, 1'b1);
		chk("ext fault", 32'h1, cmd.ext_fault);
		chk("emerg closed", 32'h1, cmd.emerg_run);
		pin(0, 1'b0);
		chk("emerg open", 32'h0, cmd.emerg_run);
		bus(1'b1, sa(0), 32'h0);
		bus(1'b1, sa(1), 32'h0);
	endtask

	// Thermistor trips on the sixth input as alarm, then as fault.
	task t_therm();
		pin(3, 1'b1);
		bus(1'b1, sa(3), 32'(FN_TH_ALM));
		pin(3, 1'b0);
		chk("therm alarm", 32'h2, 32'(cmd) & 32'h3);
		pin(3, 1'b1);
		bus(1'b1, sa(3), 32'(FN_TH_FLT));
		pin(3, 1'b0);
		chk("therm fault", 32'h1, 32'(cmd) & 32'h3);
		pin(3, 1'b1);
		chk("therm healthy", 32'h0, 32'(cmd) & 32'h3);
		bus(1'b1, sa(3), 32'h0);
	endtask

	// Reset for four cycles, then every scenario in turn.
	initial begin
		repeat (4) @(posedge hclk);
		hresetn <= 1'b1;
		t_reset();
		t_glitch();
		t_sel();
		t_level();
		t_edge();
		t_pulse();
		t_emerg();
		t_therm();
		close_out();
	end
endmodule // testbench
